// ===== core/fbc_pkg.sv
// shared constants, register map and carrier types for the backplane clocking and interleave block
package fbc_pkg;

    // ========================================================================
    // rates and frame geometry
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned PCM_BUS_HZ = 8_192_000;
    localparam int unsigned FRAME_HZ = 8_000;
    localparam int unsigned BITS_PER_FRAME = PCM_BUS_HZ / FRAME_HZ;
    localparam logic [9:0] LAST_BIT = 10'(BITS_PER_FRAME - 1);
    localparam logic [9:0] FS_ALIGN = 10'h003; // counter value after the two-flop sync latency
    localparam logic [2:0] POS_MASK = 3'h3; // four streams share the bus
    localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
    localparam logic [2:0] CHAN_LSB_BIT = 3'h7; // msb first, so bit 7 of a channel is its lsb
    localparam logic [4:0] T1_LAST_CHAN = 5'h17;
    localparam logic [4:0] E1_LAST_CHAN = 5'h1f;

    // ========================================================================
    // register byte addresses
    localparam logic [7:0] REG_IBO = 8'h00;
    localparam logic [7:0] REG_CLK2 = 8'h04;
    localparam logic [7:0] REG_CLK3 = 8'h08;
    localparam logic [7:0] REG_RX_SEL = 8'h0c;
    localparam logic [7:0] REG_TX_SEL = 8'h10;
    localparam logic [7:0] REG_FRAMES = 8'h14;
    localparam logic [7:0] REG_BP_STEP = 8'h18;

    // ========================================================================
    // field positions and reset values
    localparam int unsigned CLK2_EN_BIT = 0;
    localparam int unsigned CLK2_SEL_LSB = 1;
    localparam int unsigned CLK3_EN_BIT = 0; // rx at 0, tx at 2
    localparam int unsigned CLK3_R56_BIT = 1; // rx at 1, tx at 3
    localparam int unsigned CLK3_STRIDE = 2;
    localparam logic [5:0] IBO_RST = 6'h00;
    localparam logic [2:0] CLK2_RST = 3'h0;
    localparam logic [3:0] CLK3_RST = 4'h0;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;

    // ========================================================================
    // backplane clock synthesiser loop
    localparam logic [7:0] BP_WIN_LAST = 8'hff; // 256 reference cycles per measurement
    localparam int unsigned BP_WIN_SHIFT = 8;
    localparam int unsigned BP_GAIN_SHIFT = 19;
    localparam logic [31:0] BP_STEP_INIT = 32'h0a7c_5ac4; // about 2.048 MHz at 50 MHz

    // ========================================================================
    // carriers
    typedef struct packed {
        logic t1;       // bit 5: t1 framing on the line side
        logic fs_src;   // bit 4: this device drives the common frame sync
        logic [2:0] pos; // bits 3:1: bus position
        logic en;       // bit 0: interleaved bus option active
    } fbc_ibo_t;

    typedef struct packed {
        logic req;
        logic [4:0] chan;
    } fbc_es_req_t;

    typedef struct packed {
        logic valid;
        logic [4:0] chan;
        logic [7:0] data;
    } fbc_bus_byte_t;

endpackage

// ===== core/fbc_top.sv
// backplane interleave bus, backplane clock synthesiser and gapped channel clocks of one transceiver
`timescale 1ns/1ps
`default_nettype none

module fbc_top
    import fbc_pkg::*;
#(
    parameter logic [31:0] BP_STEP_START = BP_STEP_INIT
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after the strobe
    input wire logic pcm_clk, // 8.192 MHz backplane bus clock
    input wire logic fsync_in, // common frame sync, pin input
    output logic fsync_out, // frame sync driven as bus source
    output logic fsync_oe, // frame sync output enable
    input wire logic bus_data_in, // shared bus data, pin input
    output logic bus_data_out, // shared bus data out
    output logic bus_data_oe, // shared bus output enable
    output fbc_es_req_t es_rd, // elastic store read request, pcm_clk
    input wire logic [7:0] es_rd_data, // elastic store byte, cycle after request
    output fbc_bus_byte_t bus_rx, // byte sampled in own slot, pcm_clk
    input wire logic recovered_receive_clock, // recovered line clock, pin
    output logic backplane_clock_out, // synthesised backplane clock
    input wire logic [1:0] line_clk, // line bit clocks, 0 receive 1 transmit
    input wire logic [1:0] line_fsync, // line frame syncs, high in first bit
    output logic receive_channel_gapped_clock, // receive gapped clock
    output logic transmit_channel_gapped_clock // transmit gapped clock
);

    // ========================================================================
    // register port (clk domain)
    fbc_ibo_t interleave_bus_control;
    logic [2:0] second_clock_control;
    logic [3:0] third_clock_control;
    logic [31:0] rx_chan_select;
    logic [31:0] tx_chan_select;
    logic [15:0] frame_count;
    logic [31:0] bp_step;
    logic [31:0] next_rdata;
    logic cfg_tog;

    // software registers; selects are the per-channel fractional bits
    always_ff @(posedge clk) begin
        if (srst) begin
            interleave_bus_control <= IBO_RST;
            second_clock_control <= CLK2_RST;
            third_clock_control <= CLK3_RST;
            rx_chan_select <= SEL_RST;
            tx_chan_select <= SEL_RST;
        end else if (reg_wr) begin
            if (reg_addr == REG_IBO) begin
                interleave_bus_control <= reg_wdata[5:0];
            end else if (reg_addr == REG_CLK2) begin
                second_clock_control <= reg_wdata[2:0];
            end else if (reg_addr == REG_CLK3) begin
                third_clock_control <= reg_wdata[3:0];
            end else if (reg_addr == REG_RX_SEL) begin
                rx_chan_select <= reg_wdata;
            end else if (reg_addr == REG_TX_SEL) begin
                tx_chan_select <= reg_wdata;
            end
        end
    end

    // toggle asks the bus domain to recapture
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_tog <= 1'b0;
        end else if (reg_wr && reg_addr == REG_IBO) begin
            cfg_tog <= ~cfg_tog;
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_addr == REG_IBO) begin
            next_rdata = {26'h000_0000, interleave_bus_control};
        end else if (reg_addr == REG_CLK2) begin
            next_rdata = {29'h0000_0000, second_clock_control};
        end else if (reg_addr == REG_CLK3) begin
            next_rdata = {28'h000_0000, third_clock_control};
        end else if (reg_addr == REG_RX_SEL) begin
            next_rdata = rx_chan_select;
        end else if (reg_addr == REG_TX_SEL) begin
            next_rdata = tx_chan_select;
        end else if (reg_addr == REG_FRAMES) begin
            next_rdata = {16'h0000, frame_count};
        end else if (reg_addr == REG_BP_STEP) begin
            next_rdata = bp_step;
        end
    end

    // read data stand one cycle
    always_ff @(posedge clk) begin
        if (srst || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ========================================================================
    // bus domain reset and configuration crossing
    logic lrst_s1, lrst;
    logic ct_s1, ct_s2, ct_s3;
    fbc_ibo_t lcfg;

    // reset crosses through two flops
    always_ff @(posedge pcm_clk) begin
        lrst_s1 <= srst;
        lrst <= lrst_s1;
    end

    // word is sampled once its toggle has crossed; a second write brings its own toggle
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            ct_s1 <= 1'b0;
            ct_s2 <= 1'b0;
            ct_s3 <= 1'b0;
        end else begin
            ct_s1 <= cfg_tog;
            ct_s2 <= ct_s1;
            ct_s3 <= ct_s2;
        end
    end

    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            lcfg <= IBO_RST;
        end else if (ct_s2 ^ ct_s3) begin
            lcfg <= interleave_bus_control;
        end
    end

    // ========================================================================
    // interleaved bus timing (pcm_clk domain)
    logic fs_s1, fs_s2, fs_s3;
    logic d_s1, d_s2;
    logic [9:0] bit_cnt, next_bit, after_next, req_bit;
    logic fs_edge, own_next, own_req, own_now;
    logic [6:0] tx_sh, rx_sh;
    logic own_q1, own_q2;
    logic [9:0] cnt_q1, cnt_q2;
    logic frame_tog;

    // pins pass two flops before use
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            fs_s1 <= 1'b0;
            fs_s2 <= 1'b0;
            fs_s3 <= 1'b0;
            d_s1 <= 1'b0;
            d_s2 <= 1'b0;
        end else begin
            fs_s1 <= fsync_in;
            fs_s2 <= fs_s1;
            fs_s3 <= fs_s2;
            d_s1 <= bus_data_in;
            d_s2 <= d_s1;
        end
    end

    // slot is bit_cnt[9:3]: owner in its low bits, channel above
    always_comb begin
        fs_edge = fs_s2 & ~fs_s3 & ~lcfg.fs_src;
        if (fs_edge) begin
            next_bit = FS_ALIGN;
        end else if (bit_cnt == LAST_BIT) begin
            next_bit = 10'h000;
        end else begin
            next_bit = bit_cnt + 10'h001;
        end
        after_next = (next_bit == LAST_BIT) ? 10'h000 : next_bit + 10'h001;
        own_next = lcfg.en && ((next_bit[5:3] & POS_MASK) == (lcfg.pos & POS_MASK));
        req_bit = after_next + 10'h001;
        own_req = lcfg.en && ((req_bit[5:3] & POS_MASK) == (lcfg.pos & POS_MASK));
        own_now = lcfg.en && ((bit_cnt[5:3] & POS_MASK) == (lcfg.pos & POS_MASK));
    end

    // 1024 bits per frame, realigned on each sync edge unless this device is the sync source
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            bit_cnt <= 10'h000;
        end else begin
            bit_cnt <= next_bit;
        end
    end

    // sync source pulses in bit 0
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            fsync_out <= 1'b0;
            fsync_oe <= 1'b0;
        end else begin
            fsync_out <= lcfg.fs_src && next_bit == 10'h000;
            fsync_oe <= lcfg.fs_src;
        end
    end

    // the store is asked two bits ahead and answers a bit later;
    // it slips whole frames, so this side never waits on the line clock
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            es_rd <= '0;
        end else begin
            es_rd.req <= own_req && req_bit[2:0] == 3'h0;
            es_rd.chan <= req_bit[9:5];
        end
    end

    // drive the own slot msb first, enable low elsewhere
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            bus_data_out <= 1'b0;
            bus_data_oe <= 1'b0;
            tx_sh <= 7'h7f;
        end else begin
            bus_data_oe <= own_next;
            if (!own_next) begin
                bus_data_out <= 1'b0;
            end else if (next_bit[2:0] == 3'h0) begin
                bus_data_out <= es_rd_data[7];
                tx_sh <= es_rd_data[6:0];
            end else begin
                bus_data_out <= tx_sh[6];
                tx_sh <= {tx_sh[5:0], 1'b1};
            end
        end
    end

    // ownership delayed to match the synced bus data
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            own_q1 <= 1'b0;
            own_q2 <= 1'b0;
            cnt_q1 <= 10'h000;
            cnt_q2 <= 10'h000;
        end else begin
            own_q1 <= own_now;
            own_q2 <= own_q1;
            cnt_q1 <= bit_cnt;
            cnt_q2 <= cnt_q1;
        end
    end

    // sample the bus only in the own slot and hand out whole bytes
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            rx_sh <= 7'h00;
            bus_rx <= '0;
        end else begin
            bus_rx.valid <= own_q2 && cnt_q2[2:0] == SLOT_LAST_BIT;
            if (own_q2) begin
                rx_sh <= {rx_sh[5:0], d_s2};
                if (cnt_q2[2:0] == SLOT_LAST_BIT) begin
                    bus_rx.data <= {rx_sh, d_s2};
                    bus_rx.chan <= cnt_q2[9:5];
                end
            end
        end
    end

    // frame marker back to the register side
    always_ff @(posedge pcm_clk) begin
        if (lrst) begin
            frame_tog <= 1'b0;
        end else if (next_bit == 10'h000) begin
            frame_tog <= ~frame_tog;
        end
    end

    // ========================================================================
    // frame counter (clk domain)
    logic ft_s1, ft_s2, ft_s3;

    always_ff @(posedge clk) begin
        if (srst) begin
            ft_s1 <= 1'b0;
            ft_s2 <= 1'b0;
            ft_s3 <= 1'b0;
            frame_count <= 16'h0000;
        end else begin
            ft_s1 <= frame_tog;
            ft_s2 <= ft_s1;
            ft_s3 <= ft_s2;
            if (ft_s2 ^ ft_s3) begin
                frame_count <= frame_count + 16'h0001;
            end
        end
    end

    // ========================================================================
    // backplane clock synthesiser: digital frequency-locked oscillator
    logic rc_s1, rc_s2, rc_s3;
    logic [31:0] nco_acc;
    logic nco_msb_q;
    logic [7:0] win_cnt;
    logic [15:0] out_cnt;
    logic [15:0] expect_cnt;
    logic [31:0] step_err;
    logic rc_rise, nco_rise;

    // select 0..3 gives 1..4 times the recovered clock
    always_comb begin
        rc_rise = rc_s2 & ~rc_s3;
        nco_rise = nco_acc[31] & ~nco_msb_q;
        expect_cnt = 16'({14'h0000, second_clock_control[CLK2_SEL_LSB +: 2]} + 16'h0001) << BP_WIN_SHIFT;
        step_err = 32'(signed'({1'b0, expect_cnt}) - signed'({1'b0, out_cnt})) << BP_GAIN_SHIFT;
    end

    // one correction per window; resolution limited by clk sampling
    always_ff @(posedge clk) begin
        if (srst) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
            nco_acc <= 32'h0000_0000;
            nco_msb_q <= 1'b0;
            win_cnt <= 8'h00;
            out_cnt <= 16'h0000;
            bp_step <= BP_STEP_START;
            backplane_clock_out <= 1'b0;
        end else begin
            rc_s1 <= recovered_receive_clock;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
            nco_acc <= nco_acc + bp_step;
            nco_msb_q <= nco_acc[31];
            backplane_clock_out <= second_clock_control[CLK2_EN_BIT] & nco_acc[31];
            if (rc_rise && win_cnt == BP_WIN_LAST) begin
                win_cnt <= 8'h00;
                out_cnt <= 16'h0000;
                bp_step <= bp_step + step_err;
            end else begin
                if (rc_rise) begin
                    win_cnt <= win_cnt + 8'h01;
                end
                if (nco_rise) begin
                    out_cnt <= out_cnt + 16'h0001;
                end
            end
        end
    end

    // ========================================================================
    // gapped channel clocks, one path each for receive and transmit
    logic [1:0] gclk_q;

    generate
        for (genvar p = 0; p < 2; p++) begin : g_path
            logic lc_s1, lc_s2, lc_s3, lf_s1, lf_s2;
            logic fbit, next_fbit;
            logic [4:0] chan, next_chan;
            logic [2:0] bitn, next_bitn;
            logic active, next_active;
            logic en, r56;
            logic [31:0] sel;

            // per-path enable and rate
            always_comb begin
                en = third_clock_control[CLK3_EN_BIT + CLK3_STRIDE * p];
                r56 = third_clock_control[CLK3_R56_BIT + CLK3_STRIDE * p];
                sel = (p == 0) ? rx_chan_select : tx_chan_select;
                next_fbit = 1'b0;
                next_chan = chan;
                next_bitn = bitn + 3'h1;
                if (lf_s2) begin
                    next_fbit = interleave_bus_control.t1; // frame starts at f-bit in t1
                    next_chan = 5'h00;
                    next_bitn = 3'h0;
                end else if (fbit) begin
                    next_chan = 5'h00;
                    next_bitn = 3'h0;
                end else if (bitn == SLOT_LAST_BIT) begin
                    if (interleave_bus_control.t1 && chan == T1_LAST_CHAN) begin
                        next_fbit = 1'b1;
                        next_chan = 5'h00;
                    end else begin
                        next_chan = (chan == E1_LAST_CHAN) ? 5'h00 : chan + 5'h01;
                    end
                end
                next_active = en && !next_fbit && sel[next_chan]
                    && !(r56 && next_bitn == CHAN_LSB_BIT);
            end

            // track position on synced line clock rises
            always_ff @(posedge clk) begin
                if (srst) begin
                    lc_s1 <= 1'b0;
                    lc_s2 <= 1'b0;
                    lc_s3 <= 1'b0;
                    lf_s1 <= 1'b0;
                    lf_s2 <= 1'b0;
                    fbit <= 1'b0;
                    chan <= 5'h00;
                    bitn <= 3'h0;
                    active <= 1'b0;
                    gclk_q[p] <= 1'b0;
                end else begin
                    lc_s1 <= line_clk[p];
                    lc_s2 <= lc_s1;
                    lc_s3 <= lc_s2;
                    lf_s1 <= line_fsync[p];
                    lf_s2 <= lf_s1;
                    if (lc_s2 && !lc_s3) begin
                        fbit <= next_fbit;
                        chan <= next_chan;
                        bitn <= next_bitn;
                        active <= next_active;
                        gclk_q[p] <= next_active;
                    end else begin
                        gclk_q[p] <= lc_s2 & active & en;
                    end
                end
            end
        end
    endgenerate

    // straight from the path flops
    assign receive_channel_gapped_clock = gclk_q[0];
    assign transmit_channel_gapped_clock = gclk_q[1];

endmodule

`default_nettype wire

// ===== test/fbc_properties.sv
// port checks for the backplane clocking block
`timescale 1ns/1ps
`default_nettype none
module fbc_properties
    import fbc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic srst, // reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [31:0] reg_rdata, // read data
    input wire logic pcm_clk, // bus clock
    input wire logic fsync_out, // sync out
    input wire logic fsync_oe, // sync enable
    input wire logic bus_data_out, // bus data
    input wire logic bus_data_oe, // bus enable
    input wire fbc_es_req_t es_rd, // store request
    input wire fbc_bus_byte_t bus_rx, // sampled byte
    input wire logic backplane_clock_out, // bp clock
    input wire logic receive_channel_gapped_clock, // rx gap
    input wire logic transmit_channel_gapped_clock // tx gap
);
    // ====================
    // enables as software wrote them
    logic bp_en;
    logic [3:0] gc;
    always_ff @(posedge clk) begin
        if (srst) begin
            bp_en <= 1'b0;
            gc <= 4'h0;
        end else if (reg_wr && reg_addr == REG_CLK2) begin
            bp_en <= reg_wdata[0];
        end else if (reg_wr && reg_addr == REG_CLK3) begin
            gc <= reg_wdata[3:0];
        end
    end
    // ====================
    // bus slots and gating
    a_slot_eight_bits: assert property (@(posedge pcm_clk) disable iff (srst)
        $rose(bus_data_oe) |-> bus_data_oe [*8] ##1 !bus_data_oe) else $error("slot not 8 bits");
    a_req_leads_slot: assert property (@(posedge pcm_clk) disable iff (srst)
        es_rd.req |-> ##2 $rose(bus_data_oe)) else $error("request not before slot");
    a_idle_line_low: assert property (@(posedge pcm_clk) disable iff (srst)
        !bus_data_oe |-> !bus_data_out) else $error("data outside slot");
    a_byte_after_slot: assert property (@(posedge pcm_clk) disable iff (srst)
        $fell(bus_data_oe) |-> ##[1:3] bus_rx.valid) else $error("no sampled byte");
    a_sync_drive_on: assert property (@(posedge pcm_clk) disable iff (srst)
        fsync_out |-> fsync_oe) else $error("sync out without enable");
    a_bp_clock_gated: assert property (@(posedge clk) disable iff (srst)
        !bp_en [*3] |-> !backplane_clock_out) else $error("bp clock while off");
    a_rx_gap_gated: assert property (@(posedge clk) disable iff (srst)
        !gc[0] [*4] |-> !receive_channel_gapped_clock) else $error("rx gap while off");
    a_tx_gap_gated: assert property (@(posedge clk) disable iff (srst)
        !gc[2] [*4] |-> !transmit_channel_gapped_clock) else $error("tx gap while off");
    a_read_data_idle: assert property (@(posedge clk) disable iff (srst)
        !reg_rd |=> reg_rdata == 32'h0) else $error("read data without strobe");
    cover property (@(posedge pcm_clk) bus_rx.valid);
    cover property (@(posedge pcm_clk) $rose(fsync_out));
    cover property (@(posedge clk) $rose(receive_channel_gapped_clock));
endmodule
bind fbc_top fbc_properties i_fbc_properties (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pcm_clk, .fsync_out, .fsync_oe, .bus_data_out, .bus_data_oe, .es_rd, .bus_rx,
    .backplane_clock_out, .receive_channel_gapped_clock, .transmit_channel_gapped_clock);
`default_nettype wire

// ===== test/fbc_far_end.sv
// far side of the shared bus: backplane sync, neighbour data, elastic store
`timescale 1ns/1ps
`default_nettype none
module fbc_far_end
    import fbc_pkg::*;
(
    input wire logic pcm_clk, // bus clock
    input wire fbc_es_req_t es_rd, // store request
    output logic [7:0] es_rd_data = 8'h00, // store byte
    output logic fsync_in = 1'b0, // common sync
    input wire logic bus_data_out, // device data
    input wire logic bus_data_oe, // device enable
    output logic bus_data_in // bus level
);
    logic [9:0] bcnt = 10'h000;
    // ====================
    // backplane sync over bit 0
    always @(posedge pcm_clk) begin
        bcnt <= bcnt + 10'h1;
        fsync_in <= (bcnt == LAST_BIT);
    end
    // byte stands one bit
    always @(posedge pcm_clk) begin
        es_rd_data <= es_rd.req ? {es_rd.chan, 3'h5} : ~es_rd_data;
    end
    // neighbours toggle each bit
    assign bus_data_in = bus_data_oe ? bus_data_out : bcnt[0];
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// bench: registers, shared bus slots and gapped clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fbc_pkg::*;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pcm_clk = 0, recovered_receive_clock = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic fsync_in, fsync_out, fsync_oe, bus_data_in, bus_data_out, bus_data_oe, backplane_clock_out;
    logic receive_channel_gapped_clock, transmit_channel_gapped_clock;
    logic [1:0] line_clk = 2'h0, line_fsync = 2'h0;
    logic [7:0] es_rd_data, sh, ch;
    fbc_es_req_t es_rd;
    fbc_bus_byte_t bus_rx;
    int bad_count = 0, compares = 0, lflen = 256, lc = 0, n, n2, r, t, b;
    logic [7:0] ra [6] = '{REG_IBO, REG_CLK2, REG_CLK3, REG_RX_SEL, REG_TX_SEL, 8'h1c};
    logic [31:0] wd [5] = '{32'hffff_ffd4, '1, '1, '1, '1};
    logic [31:0] ex [5] = '{32'h14, 32'h7, 32'hf, '1, '1};
    fbc_top i_fbc_top (.*);
    fbc_far_end i_fbc_far_end (.*);
    // ====================
    // clocks; bus clock offset from clk
    initial forever #10 clk = ~clk;
    initial begin
        #7;
        forever #32 pcm_clk = ~pcm_clk;
    end
    initial forever #243 recovered_receive_clock = ~recovered_receive_clock;
    // line bits of 16 clk, sync over bit 0
    always @(posedge clk) begin
        lc <= (lc >= lflen * 16 - 1) ? 0 : lc + 1;
        line_clk <= {2{~lc[3]}};
        line_fsync <= {2{lc < 16}};
    end
    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ran_out();
        bad_count++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand one cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        cmp(reg_rdata, want);
    endtask
    // sample 1 ns after each bus edge
    task automatic wait_pcm(ref logic s, input logic v, output int k);
        for (k = 0; s !== v && k < 3000; k++) begin
            @(posedge pcm_clk);
            #1;
        end
        if (k >= 3000) ran_out();
    endtask
    // write outside the slot being enabled
    task automatic land(input int q);
        for (n2 = 0; i_fbc_far_end.bcnt[4:0] != {2'(q), 3'h1} && n2 < 100; n2++) begin
            @(posedge pcm_clk);
            #1;
        end
        if (n2 >= 100) ran_out();
    endtask
    task automatic count(input int cyc);
        logic pr, pt, pb;
        r = 0;
        t = 0;
        b = 0;
        repeat (cyc) begin
            pr = receive_channel_gapped_clock;
            pt = transmit_channel_gapped_clock;
            pb = backplane_clock_out;
            @(posedge clk);
            #1;
            r += int'(receive_channel_gapped_clock && !pr);
            t += int'(transmit_channel_gapped_clock && !pt);
            b += int'(backplane_clock_out && !pb);
        end
    endtask
    // gapped pulses over one line frame
    task automatic frame(input int er, input int et);
        for (n = 0; lc != 1 && n < 5000; n++) begin
            @(posedge clk);
            #1;
        end
        if (n >= 5000) ran_out();
        count(lflen * 16);
        cmp(32'(r), 32'(er));
        cmp(32'(t), 32'(et));
    endtask
    initial begin
        repeat (14) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) rd(ra[i], 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ra[i], wd[i]);
            rd(ra[i], ex[i]);
            wr(ra[i], 32'h0);
        end
        $display("test registers done");
        wr(REG_CLK2, 32'h7);
        count(3000);
        cmp(32'(b > 0), 32'h1);
        wr(REG_CLK2, 32'h6);
        count(100);
        count(3000);
        cmp(32'(b), 32'h0);
        $display("test backplane clock done");
        wr(REG_RX_SEL, 32'h5);
        wr(REG_TX_SEL, 32'h8000_0001);
        wr(REG_CLK3, 32'h7);
        frame(14, 16);
        lflen = 193;
        wr(REG_IBO, 32'h20);
        wr(REG_RX_SEL, 32'h00ff_ffff);
        wr(REG_CLK3, 32'h1);
        frame(192, 0);
        wr(REG_IBO, 32'h0);
        $display("test gapped clocks done");
        for (int p = 0; p < 4; p++) begin
            land(p + 2);
            wr(REG_IBO, 32'(p * 2 + 1));
            wait_pcm(fsync_in, 1'b1, n);
            wait_pcm(bus_data_oe, 1'b1, n);
            cmp(32'((n + 3) / 8), 32'(p));
            ch = {3'h0, es_rd.chan};
            cmp(ch, 32'h0);
            for (int k = 0; k < 8; k++) begin
                sh = {sh[6:0], bus_data_out};
                @(posedge pcm_clk);
                #1;
            end
            cmp(sh, {ch[4:0], 3'h5});
            for (n = 0; bus_rx.valid !== 1'b1 && n < 8; n++) begin
                @(posedge pcm_clk);
                #1;
            end
            cmp({bus_rx.chan, bus_rx.data}, {ch[4:0], ch[4:0], 3'h5});
            wr(REG_IBO, 32'h0);
        end
        land(2);
        wr(REG_IBO, 32'h11);
        wait_pcm(fsync_out, 1'b1, n);
        wait_pcm(fsync_out, 1'b0, n);
        wait_pcm(fsync_out, 1'b1, n2);
        cmp(32'(n + n2), 32'h400);
        cmp(fsync_oe, 32'h1);
        $display("test shared bus done");
        give_verdict();
    end
endmodule
`default_nettype wire
